// file: core/motion_event_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_map.svh"

module motion_event_sequencer
  import motion_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESET_N,
  input  wire logic       SAMPLE_TICK,
  input  wire logic       ACT_EVENT,
  input  wire logic       INACT_EVENT,
  input  wire logic [7:0] TAP_MAGNITUDE,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic [6:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output var  logic [7:0] REG_RDATA,
  output var  logic       ACT_ARMED,
  output var  logic       INACT_ARMED,
  output var  logic       AWAKE,
  output var  logic       WAKEUP_MODE,
  output var  logic       REF_UPDATE,
  output var  logic       FIRST_IRQ_PIN,
  output var  logic       SECOND_IRQ_PIN
);

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [7:0] tap_force_level_reg;
  logic [7:0] tap_max_length_reg;
  logic [7:0] tap_gap_time_reg;
  logic [7:0] tap_second_span_reg;
  logic [7:0] motion_ctrl_reg;
  logic [7:0] pin_route_reg;
  logic       act_flag_reg;
  logic       act_flag_next;
  logic       inact_flag_reg;
  logic       inact_flag_next;
  logic       single_flag_reg;
  logic       single_flag_next;
  logic       double_flag_reg;
  logic       double_flag_next;
  logic       measure_d_reg;
  seq_state_t state_reg;
  seq_state_t state_next;
  logic       awake_reg;
  logic       awake_next;
  logic       wakeup_reg;
  logic       wakeup_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       ref_reg;
  logic       ref_next;
  logic       pin1_reg;
  logic       pin2_reg;

  tap_if tp ();

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] ofs);
    return addr == ofs;
  endfunction

  wire wr_force  = REG_WR && hit(REG_ADDR, `OFS_TAP_FORCE_LEVEL);
  wire wr_length = REG_WR && hit(REG_ADDR, `OFS_TAP_MAX_LENGTH);
  wire wr_gap    = REG_WR && hit(REG_ADDR, `OFS_TAP_GAP_TIME);
  wire wr_span   = REG_WR && hit(REG_ADDR, `OFS_TAP_SECOND_SPAN);
  wire wr_ctrl   = REG_WR && hit(REG_ADDR, `OFS_MOTION_CTRL);
  wire wr_route  = REG_WR && hit(REG_ADDR, `OFS_PIN_ROUTE);
  wire rd_status = REG_RD && hit(REG_ADDR, `OFS_MOTION_STATUS);

  //////////////////////////////////////////////////////////////////////////////
  // control fields
  wire [1:0] link_bits  = motion_ctrl_reg[`CTL_LINK_MSB:`CTL_LINK_LSB];
  wire       is_linked  = link_bits == LINK_LINKED;
  wire       is_loop    = link_bits == LINK_LOOP;
  wire       is_chained = is_linked || is_loop;
  wire       measure    = motion_ctrl_reg[`CTL_MEASURE];
  wire       referenced = motion_ctrl_reg[`CTL_REFERENCED];
  wire       sleep_ok   = motion_ctrl_reg[`CTL_AUTOSLEEP] && is_chained
                          && !motion_ctrl_reg[`CTL_LOW_NOISE];
  wire       meas_entry = measure && !measure_d_reg;

  //////////////////////////////////////////////////////////////////////////////
  // service: host status read in linked mode, automatic in loop mode
  wire serviced   = is_loop || rd_status;
  wire act_seen   = measure && ACT_EVENT;
  wire inact_seen = measure && INACT_EVENT;

  //////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tap_force_level_reg <= `RST_TAP_REG;
      tap_max_length_reg  <= `RST_TAP_REG;
      tap_gap_time_reg    <= `RST_TAP_REG;
      tap_second_span_reg <= `RST_TAP_REG;
      motion_ctrl_reg     <= `RST_MOTION_CTRL;
      pin_route_reg       <= `RST_PIN_ROUTE;
    end else begin
      if (wr_force)  tap_force_level_reg <= REG_WDATA;
      if (wr_length) tap_max_length_reg  <= REG_WDATA;
      if (wr_gap)    tap_gap_time_reg    <= REG_WDATA;
      if (wr_span)   tap_second_span_reg <= REG_WDATA;
      if (wr_ctrl)   motion_ctrl_reg     <= REG_WDATA;
      if (wr_route)  pin_route_reg       <= REG_WDATA;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // linked/loop sequencer
  always_comb begin
    state_next = state_reg;
    if (!measure || !is_chained || meas_entry) begin
      state_next = SEEK_ACT;
    end else begin
      unique case (state_reg)
        SEEK_ACT:   if (act_seen)   state_next = ACT_PEND;
        ACT_PEND:   if (serviced)   state_next = SEEK_INACT;
        SEEK_INACT: if (inact_seen) state_next = INACT_PEND;
        INACT_PEND: if (serviced)   state_next = SEEK_ACT;
      endcase
    end
  end

  // service moments of each kind of event
  wire act_done   = state_reg == ACT_PEND && serviced && measure && is_chained;
  wire inact_done = state_reg == INACT_PEND && serviced && measure && is_chained;
  wire dflt_act   = !is_chained && act_flag_reg && rd_status;
  wire dflt_inact = !is_chained && inact_flag_reg && rd_status;

  //////////////////////////////////////////////////////////////////////////////
  // awake flag and autosleep power state
  always_comb begin
    awake_next  = awake_reg;
    wakeup_next = wakeup_reg;
    if (meas_entry) begin
      awake_next  = 1'b1;
      wakeup_next = 1'b0;
    end else if (act_done || dflt_act) begin
      awake_next  = 1'b1;
      wakeup_next = 1'b0;
    end else if (inact_done || dflt_inact) begin
      awake_next  = 1'b0;
      wakeup_next = sleep_ok;
    end
    if (!sleep_ok) wakeup_next = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // sticky status flags; an event in the clearing cycle wins
  wire act_set   = act_seen && (is_chained ? state_reg == SEEK_ACT : 1'b1);
  wire inact_set = inact_seen && (is_chained ? state_reg == SEEK_INACT : 1'b1);

  always_comb begin
    act_flag_next    = act_flag_reg;
    inact_flag_next  = inact_flag_reg;
    single_flag_next = single_flag_reg;
    double_flag_next = double_flag_reg;
    if (rd_status || act_done)   act_flag_next    = 1'b0;
    if (rd_status || inact_done) inact_flag_next  = 1'b0;
    if (rd_status)               single_flag_next = 1'b0;
    if (rd_status)               double_flag_next = 1'b0;
    if (act_set)                 act_flag_next    = 1'b1;
    if (inact_set)               inact_flag_next  = 1'b1;
    if (tp.single_hit)           single_flag_next = 1'b1;
    if (tp.double_hit)           double_flag_next = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // threshold reference refresh strobe
  always_comb begin
    ref_next = 1'b0;
    if (measure && referenced) begin
      if (is_linked)     ref_next = rd_status;
      else if (is_loop)  ref_next = act_done || inact_done;
      else               ref_next = act_set || inact_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data mux
  wire [7:0] status_word = {2'b00, wakeup_reg, awake_reg, double_flag_reg,
                            single_flag_reg, inact_flag_reg, act_flag_reg};

  always_comb begin
    rdata_next = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `OFS_TAP_FORCE_LEVEL: rdata_next = tap_force_level_reg;
        `OFS_TAP_MAX_LENGTH:  rdata_next = tap_max_length_reg;
        `OFS_TAP_GAP_TIME:    rdata_next = tap_gap_time_reg;
        `OFS_TAP_SECOND_SPAN: rdata_next = tap_second_span_reg;
        `OFS_MOTION_CTRL:     rdata_next = motion_ctrl_reg;
        `OFS_PIN_ROUTE:       rdata_next = pin_route_reg;
        `OFS_MOTION_STATUS:   rdata_next = status_word;
        default:              rdata_next = 8'h00;
      endcase
    end else begin
      rdata_next = rdata_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupt pins: each routes awake level and flag sources
  wire [3:0] pin_src = {single_flag_reg || double_flag_reg, inact_flag_reg,
                        act_flag_reg, awake_reg};
  wire       pin1    = |(pin_src & pin_route_reg[3:0]);
  wire       pin2    = |(pin_src & pin_route_reg[`ROUTE_PIN2_OFS +: 4]);

  //////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg       <= SEEK_ACT;
      awake_reg       <= 1'b1;
      wakeup_reg      <= 1'b0;
      act_flag_reg    <= 1'b0;
      inact_flag_reg  <= 1'b0;
      single_flag_reg <= 1'b0;
      double_flag_reg <= 1'b0;
      measure_d_reg   <= 1'b0;
    end else begin
      state_reg       <= state_next;
      awake_reg       <= awake_next;
      wakeup_reg      <= wakeup_next;
      act_flag_reg    <= act_flag_next;
      inact_flag_reg  <= inact_flag_next;
      single_flag_reg <= single_flag_next;
      double_flag_reg <= double_flag_next;
      measure_d_reg   <= measure;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
      ref_reg   <= 1'b0;
      pin1_reg  <= 1'b0;
      pin2_reg  <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ref_reg   <= ref_next;
      pin1_reg  <= pin1;
      pin2_reg  <= pin2;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // armed detectors follow the sequencer state in linked/loop mode; both armed in default mode
  wire act_arm_w   = measure && (!is_chained
                     || state_reg == SEEK_ACT || state_reg == ACT_PEND);
  wire inact_arm_w = measure && (!is_chained
                     || state_reg == SEEK_INACT || state_reg == INACT_PEND);

  logic act_arm_reg;
  logic inact_arm_reg;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      act_arm_reg   <= 1'b0;
      inact_arm_reg <= 1'b0;
    end else begin
      act_arm_reg   <= act_arm_w;
      inact_arm_reg <= inact_arm_w;
    end
  end

  assign REG_RDATA      = rdata_reg;
  assign ACT_ARMED      = act_arm_reg;
  assign INACT_ARMED    = inact_arm_reg;
  assign AWAKE          = awake_reg;
  assign WAKEUP_MODE    = wakeup_reg;
  assign REF_UPDATE     = ref_reg;
  assign FIRST_IRQ_PIN  = pin1_reg;
  assign SECOND_IRQ_PIN = pin2_reg;

  //////////////////////////////////////////////////////////////////////////////
  // tap detector hookup
  assign tp.tick        = SAMPLE_TICK && measure;
  assign tp.magnitude   = TAP_MAGNITUDE;
  assign tp.force_level = tap_force_level_reg;
  assign tp.max_length  = tap_max_length_reg;
  assign tp.gap_time    = tap_gap_time_reg;
  assign tp.second_span = tap_second_span_reg;
  assign tp.single_en   = motion_ctrl_reg[`CTL_SINGLE_EN];
  assign tp.double_en   = motion_ctrl_reg[`CTL_DOUBLE_EN];

  tap_detector u_tap (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .tp    (tp.detector)
  );

endmodule // motion_event_sequencer

`default_nettype wire

// file: core/motion_map.svh
`ifndef MOTION_MAP_SVH
`define MOTION_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// register offsets (7-bit address space)
`define OFS_TAP_FORCE_LEVEL   7'h2f
`define OFS_TAP_MAX_LENGTH    7'h30
`define OFS_TAP_GAP_TIME      7'h31
`define OFS_TAP_SECOND_SPAN   7'h32
`define OFS_MOTION_CTRL       7'h3c
`define OFS_PIN_ROUTE         7'h3d
`define OFS_MOTION_STATUS     7'h3e

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_TAP_REG           8'h00
`define RST_MOTION_CTRL       8'h00
`define RST_PIN_ROUTE         8'h00

////////////////////////////////////////////////////////////////////////////////
// motion control fields
`define CTL_LINK_LSB          0
`define CTL_LINK_MSB          1
`define CTL_AUTOSLEEP         2
`define CTL_LOW_NOISE         3
`define CTL_REFERENCED        4
`define CTL_SINGLE_EN         5
`define CTL_DOUBLE_EN         6
`define CTL_MEASURE           7

////////////////////////////////////////////////////////////////////////////////
// status fields; pin route uses the same four sources per pin, pin two at +4
`define STS_ACT               0
`define STS_INACT             1
`define STS_SINGLE            2
`define STS_DOUBLE            3
`define STS_AWAKE             4
`define STS_WAKEUP            5
`define ROUTE_PIN2_OFS        4

`endif

// file: core/motion_pkg.sv
package motion_pkg;

  // link setting of the activity/inactivity pair
  typedef enum logic [1:0] {
    LINK_DEFAULT = 2'h0,
    LINK_LINKED  = 2'h1,
    LINK_LOOP    = 2'h3
  } link_mode_t;

  // linked/loop sequencer states
  typedef enum logic [1:0] {SEEK_ACT, ACT_PEND, SEEK_INACT, INACT_PEND} seq_state_t;

  // tap detector states
  typedef enum logic [2:0] {T_IDLE, T_FIRST, T_GAP, T_SPAN, T_SECOND, T_DROP} tap_state_t;

endpackage

// file: core/tap_if.sv
`timescale 1ns/1ps
`default_nettype none

// settings and results between sequencer and tap detector
interface tap_if;
  logic       tick;
  logic [7:0] magnitude;
  logic [7:0] force_level;
  logic [7:0] max_length;
  logic [7:0] gap_time;
  logic [7:0] second_span;
  logic       single_en;
  logic       double_en;
  logic       single_hit;
  logic       double_hit;

  modport owner (
    output tick, magnitude, force_level, max_length, gap_time, second_span,
    output single_en, double_en,
    input  single_hit, double_hit
  );
  modport detector (
    input  tick, magnitude, force_level, max_length, gap_time, second_span,
    input  single_en, double_en,
    output single_hit, double_hit
  );
endinterface // tap_if

`default_nettype wire

// file: core/tap_detector.sv
`timescale 1ns/1ps
`default_nettype none

module tap_detector
  import motion_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst_n,
  tap_if.detector    tp
);

  tap_state_t state_reg;
  tap_state_t state_next;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       single_reg;
  logic       single_next;
  logic       double_reg;
  logic       double_next;

  // level comparison and counter limits
  wire above    = tp.magnitude > tp.force_level;
  wire too_long = count_reg >= tp.max_length;
  wire gap_done = count_reg >= tp.gap_time;
  wire span_end = count_reg >= tp.second_span;
  wire [7:0] cnt_inc = (count_reg == 8'hff) ? count_reg : count_reg + 8'h01; // saturating

  assign tp.single_hit = single_reg;
  assign tp.double_hit = double_reg;

  // per-sample tap sequence
  always_comb begin
    state_next  = state_reg;
    count_next  = count_reg;
    single_next = 1'b0;
    double_next = 1'b0;
    if (tp.tick) begin
      count_next = cnt_inc;
      unique case (state_reg)
        T_IDLE: begin
          count_next = 8'h00;
          if (above && (tp.single_en || tp.double_en)) state_next = T_FIRST;
        end
        T_FIRST: begin
          if (above && too_long) begin
            state_next = T_DROP;
          end else if (!above) begin
            count_next = 8'h00;
            if (tp.double_en) begin
              state_next = T_GAP;
            end else begin
              single_next = tp.single_en;
              state_next  = T_IDLE;
            end
          end
        end
        T_GAP: begin
          if (above) begin
            single_next = tp.single_en;
            state_next  = T_DROP;
          end else if (gap_done) begin
            count_next = 8'h00;
            state_next = T_SPAN;
          end
        end
        T_SPAN: begin
          if (above) begin
            count_next = 8'h00;
            state_next = T_SECOND;
          end else if (span_end) begin
            single_next = tp.single_en;
            state_next  = T_IDLE;
          end
        end
        T_SECOND: begin
          if (above && too_long) begin
            single_next = tp.single_en;
            state_next  = T_DROP;
          end else if (!above) begin
            single_next = tp.single_en;
            double_next = 1'b1;
            state_next  = T_IDLE;
          end
        end
        T_DROP: begin
          if (!above) state_next = T_IDLE;
        end
        default: state_next = T_IDLE;
      endcase
    end
  end

  // state and one-cycle results
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= T_IDLE;
      count_reg  <= 8'h00;
      single_reg <= 1'b0;
      double_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      count_reg  <= count_next;
      single_reg <= single_next;
      double_reg <= double_next;
    end
  end

endmodule // tap_detector

`default_nettype wire

// file: tb/motion_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_map.svh"

// watches sequencer ports for ordering and register rules
module motion_seq_chk (
  input wire logic       CORE_CLK,
  input wire logic       RESET_N,
  input wire logic       REG_WR,
  input wire logic       REG_RD,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       ACT_ARMED,
  input wire logic       INACT_ARMED,
  input wire logic       AWAKE,
  input wire logic       WAKEUP_MODE,
  input wire logic       REF_UPDATE,
  input wire logic       FIRST_IRQ_PIN,
  input wire logic       SECOND_IRQ_PIN
);
  logic [7:0] ctl_q;
  logic [7:0] rt_q;
  logic [1:0] age;
  logic [7:0] sh [4];
  // address decode and settled-mode view
  wire       rd_sts  = REG_RD && (REG_ADDR == `OFS_MOTION_STATUS);
  wire       wr_ctl  = REG_WR && (REG_ADDR == `OFS_MOTION_CTRL);
  wire       tap_a   = (REG_ADDR >= `OFS_TAP_FORCE_LEVEL) && (REG_ADDR <= `OFS_TAP_SECOND_SPAN);
  wire       mapped  = tap_a || ((REG_ADDR >= `OFS_MOTION_CTRL) && (REG_ADDR <= `OFS_MOTION_STATUS));
  wire [1:0] ti      = REG_ADDR[1:0] + 2'h1;
  wire [7:0] sh_sel  = sh[ti];
  wire       chained = (ctl_q[1:0] != 2'h0) && ctl_q[7] && (age == 2'h3);
  wire       linked  = (ctl_q[1:0] == 2'h1) && (age == 2'h3);
  // shadow copies of written registers; age counts cycles since a mode write
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctl_q <= 8'h00;
      rt_q <= 8'h00;
      age <= 2'h0;
      sh <= '{default: 8'h00};
    end else begin
      if (wr_ctl) ctl_q <= REG_WDATA;
      if (REG_WR && (REG_ADDR == `OFS_PIN_ROUTE)) rt_q <= REG_WDATA;
      if (REG_WR && tap_a) sh[ti] <= REG_WDATA;
      age <= wr_ctl ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////
  chk_awake_reset: assert property ($rose(RESET_N) |-> AWAKE)
    else $error("awake flag low after reset");
  chk_one_armed: assert property (chained |-> !(ACT_ARMED && INACT_ARMED))
    else $error("both detectors armed in chained mode");
  chk_act_first: assert property ($rose(ctl_q[7]) && (ctl_q[1:0] != 2'h0) |-> ##3 (ACT_ARMED && !INACT_ARMED))
    else $error("activity not armed first after measure entry");
  chk_inact_serv: assert property (linked && $rose(INACT_ARMED) |-> $past(rd_sts, 2))
    else $error("inactivity armed without service");
  chk_awake_fall: assert property ($fell(AWAKE) && (ctl_q[1:0] != 2'h3) |-> $past(rd_sts))
    else $error("awake cleared without service");
  chk_ref_pulse: assert property (linked && REF_UPDATE |-> $past(rd_sts) ##1 !REF_UPDATE)
    else $error("threshold refresh without status read");
  chk_wake_rise: assert property ($rose(WAKEUP_MODE) |-> (ctl_q[1:0] != 2'h0) && ctl_q[2] && !ctl_q[3])
    else $error("wake-up mode entered without autosleep");
  chk_pin1_route: assert property ((rt_q[3:0] == 4'h1) && $stable(rt_q) |-> FIRST_IRQ_PIN == $past(AWAKE))
    else $error("first pin does not follow awake");
  chk_pin2_route: assert property ((rt_q[7:4] == 4'h1) && $stable(rt_q) |-> SECOND_IRQ_PIN == $past(AWAKE))
    else $error("second pin does not follow awake");
  chk_tap_rdback: assert property (REG_RD && tap_a && !REG_WR |=> REG_RDATA == $past(sh_sel))
    else $error("tap register readback wrong");
  chk_unmapped_rd: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // motion_seq_chk

bind motion_event_sequencer motion_seq_chk u_chk (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .ACT_ARMED(ACT_ARMED), .INACT_ARMED(INACT_ARMED), .AWAKE(AWAKE),
  .WAKEUP_MODE(WAKEUP_MODE), .REF_UPDATE(REF_UPDATE),
  .FIRST_IRQ_PIN(FIRST_IRQ_PIN), .SECOND_IRQ_PIN(SECOND_IRQ_PIN));

`default_nettype wire

// file: tb/motion_host.sv
`timescale 1ns/1ps
`default_nettype none

// host processor side of the register port
module motion_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output var  logic       wr,
  output var  logic       rd,
  output var  logic [6:0] addr,
  output var  logic [7:0] wdata
);
  // idle values from time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
  end
  // one write, held over one sampling edge
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one read; a status read is the service of pending flags
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
endmodule // motion_host

`default_nettype wire

// file: tb/motion_event_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "motion_map.svh"

module motion_event_sequencer_tb_top;
  logic       clk, rst_n, tick, act, inact;
  logic [7:0] mag, d, rdata;
  logic [1:0] tcnt;
  int         compares, mismatches, cycles;
  wire        wr, rd, a_arm, i_arm, awake, wmode, pin1, pin2, refu;
  wire  [6:0] addr;
  wire  [7:0] wdata;
  logic [7:0] tv [4] = '{8'h10, 8'h04, 8'h02, 8'h08};

  motion_event_sequencer uut (.CORE_CLK(clk), .RESET_N(rst_n), .SAMPLE_TICK(tick),
    .ACT_EVENT(act), .INACT_EVENT(inact), .TAP_MAGNITUDE(mag), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .ACT_ARMED(a_arm),
    .INACT_ARMED(i_arm), .AWAKE(awake), .WAKEUP_MODE(wmode), .REF_UPDATE(refu),
    .FIRST_IRQ_PIN(pin1), .SECOND_IRQ_PIN(pin2));
  motion_host host (.clk(clk), .rdata(rdata), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));

  ////////////////////////////////////////
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // sample tick every fourth cycle, plus hang guard
  always @(posedge clk) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd_reg(a, d);
    chk(d & m, e);
  endtask
  task automatic ev(input logic a, input logic i);
    @(posedge clk);
    act <= a;
    inact <= i;
    @(posedge clk);
    act <= 1'b0;
    inact <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tap(input int n);
    @(posedge clk);
    mag <= 8'h40;
    repeat (4 * n) @(posedge clk);
    mag <= 8'h00;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    {rst_n, tick, act, inact, tcnt, mag} = '0;
    {compares, mismatches, cycles} = '0;
    cyc(16);
    chk({7'h0, awake}, 8'h01);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(`OFS_TAP_FORCE_LEVEL + 7'(i), 8'hff, 8'h00);
    rchk(7'h50, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) host.wr_reg(`OFS_TAP_FORCE_LEVEL + 7'(i), tv[i]);
    for (int i = 0; i < 4; i++) rchk(`OFS_TAP_FORCE_LEVEL + 7'(i), 8'hff, tv[i]);
    done("registers");
    // single tap only: short tap flags, long tap dropped
    host.wr_reg(`OFS_MOTION_CTRL, 8'ha0);
    tap(2);
    cyc(12);
    rchk(`OFS_MOTION_STATUS, 8'h0c, 8'h04);
    tap(8);
    cyc(40);
    rchk(`OFS_MOTION_STATUS, 8'h0c, 8'h00);
    // double enabled: single held back, second tap after latency confirms
    host.wr_reg(`OFS_MOTION_CTRL, 8'he0);
    tap(2);
    rchk(`OFS_MOTION_STATUS, 8'h0c, 8'h00);
    cyc(16);
    tap(2);
    cyc(12);
    rchk(`OFS_MOTION_STATUS, 8'h08, 8'h08);
    done("taps");
    // linked, referenced, autosleep
    host.wr_reg(`OFS_MOTION_CTRL, 8'h00);
    host.wr_reg(`OFS_MOTION_CTRL, 8'h95);
    cyc(3);
    chk({6'h0, a_arm, i_arm}, 8'h02);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    cyc(2);
    chk({6'h0, a_arm, i_arm}, 8'h02);
    rchk(`OFS_MOTION_STATUS, 8'hff, 8'h11);
    chk({7'h0, refu}, 8'h01);
    cyc(3);
    chk({6'h0, a_arm, i_arm}, 8'h01);
    ev(1'b0, 1'b1);
    rchk(`OFS_MOTION_STATUS, 8'hff, 8'h12);
    cyc(3);
    chk({4'h0, awake, wmode, a_arm, i_arm}, 8'h06);
    ev(1'b1, 1'b0);
    rchk(`OFS_MOTION_STATUS, 8'hff, 8'h21);
    cyc(3);
    chk({6'h0, awake, wmode}, 8'h02);
    done("linked");
    // default mode ignores autosleep, both detectors live
    host.wr_reg(`OFS_MOTION_CTRL, 8'h84);
    cyc(3);
    chk({6'h0, a_arm, i_arm}, 8'h03);
    ev(1'b1, 1'b1);
    rchk(`OFS_MOTION_STATUS, 8'h23, 8'h03);
    rchk(`OFS_MOTION_STATUS, 8'h03, 8'h00);
    cyc(2);
    chk({7'h0, wmode}, 8'h00);
    done("default");
    // loop mode services itself
    host.wr_reg(`OFS_MOTION_CTRL, 8'h00);
    host.wr_reg(`OFS_MOTION_CTRL, 8'h83);
    cyc(3);
    chk({5'h0, awake, a_arm, i_arm}, 8'h06);
    ev(1'b0, 1'b1);
    cyc(3);
    chk({7'h0, awake}, 8'h01);
    ev(1'b1, 1'b0);
    cyc(4);
    chk({6'h0, a_arm, i_arm}, 8'h01);
    ev(1'b0, 1'b1);
    cyc(4);
    chk({6'h0, awake, a_arm}, 8'h01);
    done("loop");
    // awake routed to either pin as a level
    host.wr_reg(`OFS_PIN_ROUTE, 8'h01);
    cyc(3);
    chk({7'h0, pin1}, 8'h00);
    ev(1'b1, 1'b0);
    cyc(4);
    chk({6'h0, pin1, pin2}, 8'h02);
    host.wr_reg(`OFS_PIN_ROUTE, 8'h10);
    cyc(3);
    chk({6'h0, pin1, pin2}, 8'h01);
    done("routing");
    summarize();
  end
endmodule // motion_event_sequencer_tb_top

`default_nettype wire
